// File: design/ffa_ecc.sv
`timescale 1ns/10ps
// =====================================================
// Per-word SEC-DED check: 32 data bits, 7 check bits
module ffa_ecc
  import ffa_pkg::*;
(
  // Coded word
  input wire logic [31:0] data_in,
  input wire logic [6:0] chk_in,
  // Corrected result
  output logic [31:0] data_out,
  output logic sbe,
  output logic dbe
);
  logic [5:0] syn;
  logic par;
  logic [31:0] flip;

  // Data bits take the non-power-of-two syndromes, check bits the rest,
  // so a flipped check bit never miscorrects a data bit
  function automatic logic [5:0] bit_pos(input int i);
    int p;
    p = i + 3;
    if (p >= 4) p++;
    if (p >= 8) p++;
    if (p >= 16) p++;
    if (p >= 32) p++;
    return 6'(p);
  endfunction

  function automatic logic [5:0] syn_calc(input logic [31:0] d);
    logic [5:0] s;
    s = 6'h00;
    for (int i = 0; i < 32; i++) begin
      if (d[i]) begin
        s = s ^ bit_pos(i);
      end
    end
    return s;
  endfunction

  always_comb begin
    syn = syn_calc(data_in) ^ chk_in[5:0];
    par = ^{data_in, chk_in};
    flip = 32'h0000_0000;
    sbe = 1'b0;
    dbe = 1'b0;
    if (par) begin
      sbe = 1'b1;
      for (int i = 0; i < 32; i++) begin
        if (syn == bit_pos(i)) begin
          flip[i] = 1'b1;
        end
      end
    end else if (syn != 6'h00) begin
      dbe = 1'b1;
    end
    data_out = data_in ^ flip;
  end
endmodule

// File: design/ffa_pkg.sv
package ffa_pkg;
  // =====================================================
  // Register map (byte addresses, one word each)
  localparam logic [7:0] FFA_OFS_CTRL = 8'h00;
  localparam logic [7:0] FFA_OFS_PROT = 8'h04;
  localparam logic [7:0] FFA_OFS_TIM0 = 8'h08;
  localparam logic [7:0] FFA_OFS_TIM1 = 8'h0c;
  localparam logic [7:0] FFA_OFS_RESTR = 8'h10;
  localparam logic [7:0] FFA_OFS_PEADR = 8'h14;
  localparam logic [7:0] FFA_OFS_PECMD = 8'h18;
  localparam logic [7:0] FFA_OFS_STAT = 8'h1c;
  localparam logic [7:0] FFA_OFS_ECCCNT = 8'h20;
  localparam logic [7:0] FFA_OFS_PEDATA = 8'h24;
  // =====================================================
  // Control fields
  localparam int FFA_CTRL_BUF_EN = 0;
  localparam int FFA_CTRL_PF_EN = 1;
  localparam logic [31:0] FFA_CTRL_RST = 32'h0000_0003;
  localparam logic [31:0] FFA_PROT_RST = 32'h0000_003f;
  localparam logic [31:0] FFA_TIM_RST = 32'h0000_0000;
  localparam logic [31:0] FFA_RESTR_RST = 32'h0000_0000;
  // Command codes
  localparam logic [1:0] FFA_CMD_PROG = 2'h1;
  localparam logic [1:0] FFA_CMD_ERASE = 2'h2;
  localparam logic [1:0] FFA_CMD_SUSP = 2'h3;
  // Status bits
  localparam int FFA_ST_BUSY = 0;
  localparam int FFA_ST_SUSP = 1;
  localparam int FFA_ST_DENIED = 2;
  localparam int FFA_ST_SBE = 3;
  localparam int FFA_ST_DBE = 4;
  // =====================================================
  // Masters and sizes
  localparam logic [1:0] FFA_M_FETCH = 2'h0;
  localparam logic [1:0] FFA_M_LOAD = 2'h1;
  localparam logic [1:0] FFA_M_DMA = 2'h2;
  localparam logic [1:0] FFA_SZ_B = 2'h0;
  localparam logic [1:0] FFA_SZ_H = 2'h1;
  localparam logic [1:0] FFA_SZ_W = 2'h2;
  localparam logic [1:0] FFA_SZ_D = 2'h3;
  // Miss latency: three wait states before the registered answer
  localparam int FFA_MISS_WAIT = 3;
  localparam int FFA_LINES = 4;
  localparam int FFA_BLOCKS = 8;
  localparam logic [2:0] FFA_SHADOW_BLK = 3'h7;
  // Embedded algorithm durations in cycles
  localparam logic [7:0] FFA_PROG_CYC = 8'h20;
  localparam logic [7:0] FFA_ERASE_CYC = 8'hff;

  typedef enum logic [1:0] {
    FFA_IDLE = 2'b00,
    FFA_ISSUE = 2'b01,
    FFA_WAIT = 2'b11,
    FFA_RESP = 2'b10
  } ffa_state_t;
endpackage

// File: design/ffa_top.sv
`timescale 1ns/10ps
module ffa_top
  import ffa_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Hardware permission straps, two bits per master
  input wire logic [5:0] prot_strap,
  // System bus request
  input wire logic bus_req,
  input wire logic [1:0] bus_master,
  input wire logic bus_write,
  input wire logic [1:0] bus_size,
  input wire logic [23:0] bus_addr,
  input wire logic bus_map,
  // System bus answer
  output logic bus_ready,
  output logic bus_err,
  output logic [63:0] bus_rdata,
  // Array read port, 128 data bits plus 4x7 check bits
  output logic arr_req,
  output logic [19:0] arr_line,
  input wire logic arr_ack,
  input wire logic [127:0] arr_data,
  input wire logic [27:0] arr_chk,
  // APB register port
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  // =====================================================
  // Registers
  logic [31:0] ctrl_q, prot_q, tim0_q, tim1_q, restr_q, peadr_q;
  logic [31:0] pedata_q, ecccnt_q;
  logic busy_q, susp_q, denied_q, sbe_q, dbe_q;
  logic [1:0] pecmd_q;
  logic [7:0] pecnt_q;
  logic strap_done_q;
  logic apb_wr, apb_rd;
  logic [31:0] rd_mux;

  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && penable && !pwrite;

  function automatic logic known_ofs(input logic [7:0] a);
    return a <= FFA_OFS_PEDATA && a[1:0] == 2'b00;
  endfunction

  // Protection loads straps once after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prot_q <= FFA_PROT_RST;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      prot_q <= {26'h0, prot_strap};
      strap_done_q <= 1'b1;
    end else if (apb_wr && paddr == FFA_OFS_PROT) begin
      prot_q <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= FFA_CTRL_RST;
      tim0_q <= FFA_TIM_RST;
      tim1_q <= FFA_TIM_RST;
      restr_q <= FFA_RESTR_RST;
      peadr_q <= 32'h0000_0000;
      pedata_q <= 32'h0000_0000;
    end else if (apb_wr) begin
      case (paddr)
        FFA_OFS_CTRL: ctrl_q <= pwdata;
        FFA_OFS_TIM0: tim0_q <= {27'h0, pwdata[4:0]};
        FFA_OFS_TIM1: tim1_q <= {27'h0, pwdata[4:0]};
        FFA_OFS_RESTR: restr_q <= pwdata;
        FFA_OFS_PEADR: peadr_q <= pwdata;
        FFA_OFS_PEDATA: pedata_q <= pwdata;
        default: ;
      endcase
    end
  end

  // =====================================================
  // Embedded program and erase sequencer
  logic pe_go, pe_blk_ok, pe_align_ok;
  logic [2:0] pe_blk;
  assign pe_go = apb_wr && paddr == FFA_OFS_PECMD;
  assign pe_blk = peadr_q[23:21];
  // Shadow block has its own restriction bit, so it stands alone
  assign pe_blk_ok = !restr_q[pe_blk];
  assign pe_align_ok = peadr_q[2:0] == 3'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
      susp_q <= 1'b0;
      denied_q <= 1'b0;
      pecmd_q <= 2'h0;
      pecnt_q <= 8'h00;
    end else begin
      if (apb_wr && paddr == FFA_OFS_STAT && pwdata[FFA_ST_DENIED]) begin
        denied_q <= 1'b0;
      end
      if (pe_go) begin
        if (pwdata[1:0] == FFA_CMD_SUSP) begin
          if (busy_q && pecmd_q == FFA_CMD_ERASE) begin
            susp_q <= !susp_q;
          end
        end else if (!busy_q && pwdata[1:0] != 2'h0) begin
          if (!pe_blk_ok || (pwdata[1:0] == FFA_CMD_PROG &&
              !pe_align_ok)) begin
            denied_q <= 1'b1;
          end else begin
            busy_q <= 1'b1;
            pecmd_q <= pwdata[1:0];
            pecnt_q <= (pwdata[1:0] == FFA_CMD_PROG) ?
                       FFA_PROG_CYC : FFA_ERASE_CYC;
          end
        end
      end else if (busy_q && !susp_q) begin
        if (pecnt_q == 8'h00) begin
          busy_q <= 1'b0;
        end else begin
          pecnt_q <= pecnt_q - 8'h01;
        end
      end
    end
  end

  // =====================================================
  // Prefetch buffer: tag, data, valid, age per line
  logic [127:0] line_d_q [FFA_LINES];
  logic [19:0] line_t_q [FFA_LINES];
  logic [FFA_LINES-1:0] line_v_q;
  logic [1:0] age_q [FFA_LINES];
  logic [19:0] req_line;
  logic hit;
  logic [1:0] hit_idx, vict_idx;

  assign req_line = bus_addr[23:4];

  always_comb begin
    hit = 1'b0;
    hit_idx = 2'h0;
    vict_idx = 2'h0;
    for (int i = 0; i < FFA_LINES; i++) begin
      if (line_v_q[i] && line_t_q[i] == req_line) begin
        hit = ctrl_q[FFA_CTRL_BUF_EN];
        hit_idx = 2'(i);
      end
      if (age_q[i] == 2'h3) begin
        vict_idx = 2'(i);
      end
    end
  end

  function automatic logic [63:0] pick_half(input logic [127:0] l,
                                            input logic hi);
    return hi ? l[127:64] : l[63:0];
  endfunction

  // =====================================================
  // Bus request path
  ffa_state_t st_q;
  logic [4:0] wait_q;
  logic [1:0] fill_q;
  logic pf_q, pf_pend_q;
  logic [19:0] pf_line_q;
  logic rd_ok, wr_ok, fill_go, take;
  logic [127:0] fixed;
  logic [3:0] sbe_v, dbe_v;
  logic [4:0] map_wait;

  assign rd_ok = prot_q[{bus_master, 1'b0}];
  assign wr_ok = prot_q[{bus_master, 1'b1}] &&
                 (bus_size == FFA_SZ_W || bus_size == FFA_SZ_D) &&
                 (bus_size == FFA_SZ_W ? bus_addr[1:0] == 2'h0 :
                  bus_addr[2:0] == 3'h0);
  assign map_wait = bus_map ? tim1_q[4:0] : tim0_q[4:0];
  assign fill_go = arr_req && arr_ack && wait_q == 5'h00;
  // The answering edge still sees the finished request held
  assign take = bus_req && !bus_ready;

  for (genvar g = 0; g < 4; g++) begin : g_ecc
    ffa_ecc u_ecc (
      .data_in(arr_data[32*g +: 32]),
      .chk_in(arr_chk[7*g +: 7]),
      .data_out(fixed[32*g +: 32]),
      .sbe(sbe_v[g]),
      .dbe(dbe_v[g])
    );
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= FFA_IDLE;
      bus_ready <= 1'b0;
      bus_err <= 1'b0;
      bus_rdata <= 64'h0;
      arr_req <= 1'b0;
      arr_line <= 20'h0;
      wait_q <= 5'h00;
      pf_q <= 1'b0;
      pf_pend_q <= 1'b0;
      pf_line_q <= 20'h0;
      fill_q <= 2'h0;
    end else begin
      bus_ready <= 1'b0;
      bus_err <= 1'b0;
      if (wait_q != 5'h00 && st_q == FFA_WAIT) begin
        wait_q <= wait_q - 5'h01;
      end
      case (st_q)
        FFA_IDLE: begin
          if (take && !(bus_write ? wr_ok : rd_ok)) begin
            bus_ready <= 1'b1;
            bus_err <= 1'b1;
          end else if (take && bus_write) begin
            // Array writes go through the sequencer registers
            bus_ready <= 1'b1;
          end else if (take && hit) begin
            bus_ready <= 1'b1;
            bus_rdata <= pick_half(line_d_q[hit_idx], bus_addr[3]);
            if (bus_master == FFA_M_FETCH && ctrl_q[FFA_CTRL_PF_EN]) begin
              pf_pend_q <= 1'b1;
              pf_line_q <= req_line + 20'h1;
            end
          end else if (take) begin
            arr_req <= 1'b1;
            arr_line <= req_line;
            wait_q <= map_wait;
            pf_q <= 1'b0;
            fill_q <= bus_addr[3] ? 2'h1 : 2'h0;
            st_q <= FFA_ISSUE;
            pf_pend_q <= bus_master == FFA_M_FETCH &&
                         ctrl_q[FFA_CTRL_PF_EN];
            pf_line_q <= req_line + 20'h1;
          end else if (pf_pend_q) begin
            pf_pend_q <= 1'b0;
            arr_req <= 1'b1;
            arr_line <= pf_line_q;
            wait_q <= tim0_q[4:0];
            pf_q <= 1'b1;
            st_q <= FFA_ISSUE;
          end
        end
        FFA_ISSUE: begin
          st_q <= FFA_WAIT;
        end
        FFA_WAIT: begin
          if (fill_go) begin
            arr_req <= 1'b0;
            st_q <= pf_q ? FFA_IDLE : FFA_RESP;
            bus_rdata <= pick_half(fixed, fill_q[0]);
          end
        end
        FFA_RESP: begin
          bus_ready <= 1'b1;
          bus_err <= |dbe_q;
          st_q <= FFA_IDLE;
        end
        default: st_q <= FFA_IDLE;
      endcase
    end
  end

  // Line fill, LRU ages and ECC status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_v_q <= '0;
      sbe_q <= 1'b0;
      dbe_q <= 1'b0;
      ecccnt_q <= 32'h0;
      for (int i = 0; i < FFA_LINES; i++) begin
        line_d_q[i] <= 128'h0;
        line_t_q[i] <= 20'h0;
        age_q[i] <= 2'(i);
      end
    end else begin
      if (apb_wr && paddr == FFA_OFS_STAT && pwdata[FFA_ST_SBE]) begin
        sbe_q <= 1'b0;
      end
      if (st_q == FFA_WAIT && fill_go) begin
        dbe_q <= |dbe_v;
        if (|sbe_v) begin
          sbe_q <= 1'b1;
          ecccnt_q <= ecccnt_q + 32'h1;
        end
        if (ctrl_q[FFA_CTRL_BUF_EN] && !(|dbe_v)) begin
          line_d_q[vict_idx] <= fixed;
          line_t_q[vict_idx] <= arr_line;
          line_v_q[vict_idx] <= 1'b1;
          for (int i = 0; i < FFA_LINES; i++) begin
            if (age_q[i] < age_q[vict_idx]) begin
              age_q[i] <= age_q[i] + 2'h1;
            end
          end
          age_q[vict_idx] <= 2'h0;
        end
      end else if (st_q == FFA_IDLE && take && hit && !bus_write) begin
        for (int i = 0; i < FFA_LINES; i++) begin
          if (age_q[i] < age_q[hit_idx]) begin
            age_q[i] <= age_q[i] + 2'h1;
          end
        end
        age_q[hit_idx] <= 2'h0;
      end
      if (!ctrl_q[FFA_CTRL_BUF_EN]) begin
        line_v_q <= '0;
      end
    end
  end

  // =====================================================
  // APB read side: zero wait, error on unmapped
  always_comb begin
    case (paddr)
      FFA_OFS_CTRL: rd_mux = ctrl_q;
      FFA_OFS_PROT: rd_mux = prot_q;
      FFA_OFS_TIM0: rd_mux = tim0_q;
      FFA_OFS_TIM1: rd_mux = tim1_q;
      FFA_OFS_RESTR: rd_mux = restr_q;
      FFA_OFS_PEADR: rd_mux = peadr_q;
      FFA_OFS_PECMD: rd_mux = {30'h0, pecmd_q};
      FFA_OFS_STAT: rd_mux = {27'h0, dbe_q, sbe_q, denied_q, susp_q,
                              busy_q};
      FFA_OFS_ECCCNT: rd_mux = ecccnt_q;
      FFA_OFS_PEDATA: rd_mux = pedata_q;
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !known_ofs(paddr);
      if (psel && !penable && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end
endmodule

// File: dv/ffa_array_model.sv
`timescale 1ns/10ps
// ====
// Array controller answering line reads
module ffa_array_model
  import ffa_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Array read port
  input wire logic arr_req,
  input wire logic [19:0] arr_line,
  output logic arr_ack,
  output logic [127:0] arr_data,
  output logic [27:0] arr_chk,
  // Answer delay; fault 1 flips one bit, 2 flips two
  input wire logic [4:0] lat,
  input wire logic [1:0] flip
);
  logic [4:0] cnt_q;
  // Syndrome of data bit i: the i-th value from 3 up that is no power of 2
  function automatic logic [5:0] code_pos(input int i);
    int q;
    q = i + 3;
    if (q >= 4) q++;
    if (q >= 8) q++;
    if (q >= 16) q++;
    if (q >= 32) q++;
    return 6'(q);
  endfunction
  function automatic logic [6:0] ecc(input logic [31:0] d);
    logic [5:0] p;
    p = 6'h00;
    for (int i = 0; i < 32; i++) begin
      if (d[i]) p ^= code_pos(i);
    end
    return {^d ^ ^p, p};
  endfunction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 5'h00;
      arr_ack <= 1'b0;
      arr_data <= '0;
      arr_chk <= '0;
    end else if (arr_req && cnt_q >= lat) begin
      arr_ack <= 1'b1;
      for (int w = 0; w < 4; w++) begin
        arr_data[32*w +: 32] <= {arr_line, 2'(w), 10'h2a5};
        arr_chk[7*w +: 7] <= ecc({arr_line, 2'(w), 10'h2a5});
      end
      if (flip != 2'h0) arr_data[5] <= 1'b0;
      if (flip == 2'h2) arr_data[6] <= 1'b1;
    end else begin
      // Idle lines invert every cycle instead of holding the last word
      arr_ack <= 1'b0;
      cnt_q <= arr_req ? cnt_q + 5'h01 : 5'h00;
      arr_data <= ~arr_data;
      arr_chk <= ~arr_chk;
    end
  end
endmodule

// File: dv/ffa_assertions.sv
`timescale 1ns/10ps
// ====
// Port checks of the fetch front end
module ffa_checker
  import ffa_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // System bus
  input wire logic bus_req,
  input wire logic [1:0] bus_master,
  input wire logic bus_write,
  input wire logic [1:0] bus_size,
  input wire logic [23:0] bus_addr,
  input wire logic bus_ready,
  input wire logic bus_err,
  // Array port
  input wire logic arr_req,
  input wire logic [19:0] arr_line,
  input wire logic arr_ack,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr
);
  logic last_fetch_q;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  sequence s_fault_end;
    ##[1:40] bus_ready && bus_err;
  endsequence
  // A prefetch may only follow an answered fetch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_fetch_q <= 1'b0;
    end else if (bus_ready) begin
      last_fetch_q <= bus_master == FFA_M_FETCH;
    end
  end
  a_apb_answer: assert property (s_setup |=> s_access)
    else $error("apb access not answered at once");
  a_slverr_access: assert property (pslverr |-> pready && penable)
    else $error("slave error outside access");
  a_ready_pulse: assert property (bus_ready |=> !bus_ready)
    else $error("bus ready longer than one cycle");
  a_err_with_ready: assert property (bus_err |-> bus_ready)
    else $error("bus error without ready");
  a_narrow_write: assert property ($rose(bus_req) && bus_write &&
    !bus_size[1] |-> s_fault_end)
    else $error("narrow write not refused");
  a_misalign_write: assert property ($rose(bus_req) && bus_write &&
    bus_size == FFA_SZ_W && bus_addr[1:0] != 2'h0 |-> s_fault_end)
    else $error("misaligned write not refused");
  a_arr_hold: assert property (arr_req && !arr_ack |=>
    arr_req && $stable(arr_line))
    else $error("array request dropped early");
  a_line_addr: assert property ($rose(arr_req) && bus_req &&
    bus_master != FFA_M_FETCH |-> arr_line == bus_addr[23:4])
    else $error("array line differs from bus address");
  a_fetch_only_pf: assert property ($rose(arr_req) && !bus_req |->
    last_fetch_q)
    else $error("prefetch after non-fetch access");
endmodule

bind ffa_top ffa_checker u_ffa_checker (
  .pclk, .presetn, .bus_req, .bus_master, .bus_write, .bus_size,
  .bus_addr, .bus_ready, .bus_err, .arr_req, .arr_line, .arr_ack,
  .psel, .penable, .pready, .pslverr
);

// File: dv/test_flash_fetch_accelerator.sv
`timescale 1ns/10ps
module test_flash_fetch_accelerator import ffa_pkg::*;;
  logic pclk, presetn, bus_req, bus_write, bus_map, bus_ready, bus_err;
  logic psel, penable, pwrite, pready, pslverr, arr_req, arr_ack;
  logic [1:0] bus_master, bus_size, flip;
  logic [4:0] lat;
  logic [5:0] prot_strap;
  logic [7:0] paddr;
  logic [19:0] arr_line;
  logic [23:0] bus_addr, a, b;
  logic [27:0] arr_chk;
  logic [31:0] pwdata, prdata, rd;
  logic [63:0] bus_rdata;
  logic [127:0] arr_data;
  logic [33:0] aq[$], ea;
  logic [65:0] bq[$], eb;
  int errors, cmp_count;
  ffa_top u_ffa_top (.pclk(pclk), .presetn(presetn),
    .prot_strap(prot_strap), .bus_req(bus_req), .bus_master(bus_master),
    .bus_write(bus_write), .bus_size(bus_size), .bus_addr(bus_addr),
    .bus_map(bus_map), .bus_ready(bus_ready), .bus_err(bus_err),
    .bus_rdata(bus_rdata), .arr_req(arr_req), .arr_line(arr_line),
    .arr_ack(arr_ack), .arr_data(arr_data), .arr_chk(arr_chk),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  ffa_array_model u_ffa_array_model (.pclk(pclk), .presetn(presetn),
    .arr_req(arr_req), .arr_line(arr_line), .arr_ack(arr_ack),
    .arr_data(arr_data), .arr_chk(arr_chk), .lat(lat), .flip(flip));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  function automatic logic [63:0] exp_rd(input logic [23:0] ad);
    return {ad[23:4], ad[3], 1'b1, 10'h2a5, ad[23:4], ad[3], 1'b0, 10'h2a5};
  endfunction
  task automatic check(input logic [65:0] g, input logic [65:0] x);
    cmp_count++;
    if (g !== x) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ====
  // Drivers: expected results queued, monitor compares
  task automatic apb(input logic w, input logic [7:0] ad,
      input logic [31:0] d, input logic [33:0] x);
    int n;
    aq.push_back(x);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    if (n >= 50) begin
      errors++;
      close_out();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic bus(input logic [1:0] m, input logic w,
      input logic [1:0] sz, input logic [23:0] ad, input logic mp,
      input logic er, input int lt);
    int n;
    bq.push_back({~w & ~er, er, (w | er) ? 64'h0 : exp_rd(ad)});
    bus_req <= 1'b1;
    bus_master <= m;
    bus_write <= w;
    bus_size <= sz;
    bus_addr <= ad;
    bus_map <= mp;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (bus_ready !== 1'b1 && n < 100);
    check({34'h0, n}, {34'h0, lt});
    if (n >= 100) close_out();
    bus_req <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic poll_idle();
    rd = 32'h1;
    for (int n = 0; n < 200 && rd[FFA_ST_BUSY] !== 1'b0; n++) begin
      apb(1'b0, FFA_OFS_STAT, 32'h0, 34'h0);
    end
    if (rd[FFA_ST_BUSY] !== 1'b0) begin
      errors++;
      close_out();
    end
  endtask
  always @(posedge pclk) begin
    if (bus_ready === 1'b1) begin
      eb = bq.size() > 0 ? bq.pop_front() : '1;
      check({eb[65], bus_err, eb[65] ? bus_rdata : 64'h0}, eb);
    end
    if (psel && penable && pready === 1'b1) begin
      ea = aq.size() > 0 ? aq.pop_front() : '1;
      check({32'h0, ea[33], pslverr, ea[33] ? prdata : 32'h0}, {32'h0, ea});
    end
  end
  // ====
  // Scenarios
  initial begin
    void'($urandom(32'hd3369c29));
    {presetn, bus_req, bus_write, bus_map, psel, penable, pwrite} = '0;
    {bus_master, bus_size, flip, lat, paddr, bus_addr, pwdata} = '0;
    prot_strap = 6'h1f;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    apb(1'b0, FFA_OFS_CTRL, 32'h0, {2'b10, FFA_CTRL_RST});
    apb(1'b0, FFA_OFS_PROT, 32'h0, {2'b10, 26'h0, 6'h1f});
    apb(1'b0, FFA_OFS_TIM1, 32'h0, {2'b10, FFA_TIM_RST});
    apb(1'b1, 8'h28, 32'h5, {2'b01, 32'h0});
    $display("test registers done");
    a = {4'h8, 16'($urandom), 4'h0};
    bus(FFA_M_FETCH, 1'b0, FFA_SZ_D, a, 1'b0, 1'b0, 5);
    repeat (20) @(posedge pclk);
    bus(FFA_M_FETCH, 1'b0, FFA_SZ_W, a + 24'h8, 1'b0, 1'b0, 2);
    repeat (20) @(posedge pclk);
    bus(FFA_M_FETCH, 1'b0, FFA_SZ_B, a + 24'h13, 1'b0, 1'b0, 2);
    repeat (20) @(posedge pclk);
    bus(FFA_M_LOAD, 1'b0, FFA_SZ_H, a + 24'h40, 1'b0, 1'b0, 5);
    repeat (20) @(posedge pclk);
    bus(FFA_M_DMA, 1'b0, FFA_SZ_W, a + 24'h50, 1'b0, 1'b0, 5);
    $display("test prefetch done");
    b = 24'h010000;
    apb(1'b1, FFA_OFS_CTRL, 32'h0, 34'h0);
    apb(1'b1, FFA_OFS_CTRL, 32'h1, 34'h0);
    for (int k = 0; k < 4; k++) begin
      bus(FFA_M_LOAD, 1'b0, FFA_SZ_W, b + 24'(k * 16), 1'b0, 1'b0, 5);
    end
    bus(FFA_M_LOAD, 1'b0, FFA_SZ_W, b, 1'b0, 1'b0, 2);
    bus(FFA_M_LOAD, 1'b0, FFA_SZ_W, b + 24'h40, 1'b0, 1'b0, 5);
    bus(FFA_M_LOAD, 1'b0, FFA_SZ_W, b, 1'b0, 1'b0, 2);
    bus(FFA_M_LOAD, 1'b0, FFA_SZ_W, b + 24'h10, 1'b0, 1'b0, 5);
    $display("test replacement done");
    apb(1'b1, FFA_OFS_CTRL, 32'h0, 34'h0);
    bus(FFA_M_LOAD, 1'b0, FFA_SZ_W, b, 1'b0, 1'b0, 5);
    apb(1'b1, FFA_OFS_TIM1, 32'h1f, 34'h0);
    bus(FFA_M_LOAD, 1'b0, FFA_SZ_W, b, 1'b1, 1'b0, 36);
    lat <= 5'h3;
    bus(FFA_M_LOAD, 1'b0, FFA_SZ_W, b + 24'h30, 1'b0, 1'b0, 8);
    lat <= 5'h0;
    $display("test timing done");
    bus(FFA_M_LOAD, 1'b1, FFA_SZ_B, b, 1'b0, 1'b1, 2);
    bus(FFA_M_LOAD, 1'b1, FFA_SZ_W, b + 24'h2, 1'b0, 1'b1, 2);
    bus(FFA_M_LOAD, 1'b1, FFA_SZ_D, b + 24'h8, 1'b0, 1'b0, 2);
    bus(FFA_M_DMA, 1'b1, FFA_SZ_W, b, 1'b0, 1'b1, 2);
    apb(1'b1, FFA_OFS_PROT, 32'h2f, 34'h0);
    bus(FFA_M_DMA, 1'b0, FFA_SZ_W, b, 1'b0, 1'b1, 2);
    $display("test faults done");
    apb(1'b1, FFA_OFS_RESTR, 32'h4, 34'h0);
    apb(1'b1, FFA_OFS_PEADR, {8'h0, 3'h2, 21'h0}, 34'h0);
    apb(1'b1, FFA_OFS_PECMD, {30'h0, FFA_CMD_PROG}, 34'h0);
    apb(1'b0, FFA_OFS_STAT, 32'h0, {2'b10, 32'h4});
    apb(1'b1, FFA_OFS_STAT, 32'h4, 34'h0);
    apb(1'b1, FFA_OFS_PEADR, {8'h0, 3'h1, 21'h4}, 34'h0);
    apb(1'b1, FFA_OFS_PECMD, {30'h0, FFA_CMD_PROG}, 34'h0);
    apb(1'b0, FFA_OFS_STAT, 32'h0, {2'b10, 32'h4});
    apb(1'b1, FFA_OFS_STAT, 32'h4, 34'h0);
    apb(1'b1, FFA_OFS_PEADR, {8'h0, 3'h1, 21'h8}, 34'h0);
    apb(1'b1, FFA_OFS_PEDATA, $urandom, 34'h0);
    apb(1'b1, FFA_OFS_PECMD, {30'h0, FFA_CMD_PROG}, 34'h0);
    apb(1'b0, FFA_OFS_STAT, 32'h0, {2'b10, 32'h1});
    poll_idle();
    apb(1'b1, FFA_OFS_PECMD, {30'h0, FFA_CMD_ERASE}, 34'h0);
    apb(1'b1, FFA_OFS_PECMD, {30'h0, FFA_CMD_SUSP}, 34'h0);
    apb(1'b0, FFA_OFS_STAT, 32'h0, {2'b10, 32'h3});
    apb(1'b1, FFA_OFS_PECMD, {30'h0, FFA_CMD_SUSP}, 34'h0);
    poll_idle();
    apb(1'b1, FFA_OFS_RESTR, 32'h7f, 34'h0);
    apb(1'b1, FFA_OFS_PEADR, {8'h0, FFA_SHADOW_BLK, 21'h0}, 34'h0);
    apb(1'b1, FFA_OFS_PECMD, {30'h0, FFA_CMD_ERASE}, 34'h0);
    apb(1'b0, FFA_OFS_STAT, 32'h0, {2'b10, 32'h1});
    poll_idle();
    $display("test program erase done");
    flip <= 2'h1;
    bus(FFA_M_LOAD, 1'b0, FFA_SZ_D, b + 24'h20, 1'b0, 1'b0, 5);
    apb(1'b0, FFA_OFS_ECCCNT, 32'h0, {2'b10, 32'h1});
    apb(1'b0, FFA_OFS_STAT, 32'h0, {2'b10, 32'h8});
    apb(1'b1, FFA_OFS_STAT, 32'h8, 34'h0);
    apb(1'b0, FFA_OFS_STAT, 32'h0, {2'b10, 32'h0});
    flip <= 2'h2;
    bus(FFA_M_LOAD, 1'b0, FFA_SZ_D, b + 24'h20, 1'b0, 1'b1, 5);
    $display("test ecc done");
    close_out();
  end
endmodule
